/* File: rtl/nvac_regs.vh */
/*
 * Register map, bit positions and timing counts of the nonvolatile
 * memory access controller. Assumes a 32-bit APB slave, 100 MHz pclk.
 */
`ifndef NVAC_REGS_VH
`define NVAC_REGS_VH

// Byte offsets on APB
`define NVAC_OFS_CTRL     12'h000
`define NVAC_OFS_UNLOCK   12'h004
`define NVAC_OFS_EEPROM_DATA_REG   12'h008
`define NVAC_OFS_EEADDR   12'h00c
`define NVAC_OFS_TBLU     12'h010
`define NVAC_OFS_TBLH     12'h014
`define NVAC_OFS_TBLL     12'h018
`define NVAC_OFS_TBLAT    12'h01c
`define NVAC_OFS_FLAGS2   12'h020
`define NVAC_OFS_ENABLES2 12'h024
`define NVAC_OFS_PRIO2    12'h028
`define NVAC_OFS_STATUS   12'h02c

// Control register bits and the FLAGS2 done bit
`define NVAC_B_SPACE 7
`define NVAC_B_CONFIG_SPACE_SELECT  6
`define NVAC_B_ERASE 4
`define NVAC_B_ABORT 3
`define NVAC_B_WEN   2
`define NVAC_B_WSTRT 1
`define NVAC_B_RSTRT 0
`define NVAC_B_DONE  4

// Unlock keys
`define NVAC_KEY1 8'h55
`define NVAC_KEY2 8'haa

// Reset value and TBLU write mask
`define NVAC_CTRL_RST 8'h00
`define NVAC_TBLU_MASK 8'h3f

// Timing: write time in us and power-up timer in us
`define NVAC_WRITE_US 2000
`define NVAC_PWRT_US  65536
`define NVAC_CLK_MHZ  100

`endif

/* File: rtl/nvac_ctrl.v */
/*
 * Access control for data EEPROM, program flash and configuration space:
 * control register, unlock port, data EEPROM byte reads and self-timed writes.
 * Assumes an APB master on pclk and an external array model on the
 * memory-side ports that samples mem_wr_pulse and answers mem_rdata.
 */
`default_nettype none

`include "nvac_regs.vh"

module nvac_ctrl #(
  parameter integer WRITE_CYCLES = `NVAC_WRITE_US * `NVAC_CLK_MHZ,
  parameter integer PWRT_CYCLES  = `NVAC_PWRT_US * `NVAC_CLK_MHZ
) (
  // Clock, reset, enable
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Reset cause: high for a power-on reset, low for other resets
  input  wire        por_flag,
  // Memory array side
  output reg  [1:0]  mem_space,
  output reg  [7:0]  mem_addr,
  output reg  [21:0] mem_tbl_addr,
  output reg  [7:0]  mem_wdata,
  output reg         mem_erase_pulse,
  output reg         mem_wr_pulse,
  output reg         mem_rd_pulse,
  input  wire [7:0]  mem_rdata,
  // Core stall and done event level
  output wire        core_stall,
  output wire        write_done_flag
);

  localparam [1:0] SP_EEPROM = 2'd0;
  localparam [1:0] SP_FLASH  = 2'd1;
  localparam [1:0] SP_CONFIG = 2'd2;

  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_ERASE = 2'd1;
  localparam [1:0] ST_PROG  = 2'd2;

  localparam [1:0] UL_NONE = 2'd0;
  localparam [1:0] UL_K1   = 2'd1;
  localparam [1:0] UL_K2   = 2'd2;

  localparam [31:0] HALF_CYC = WRITE_CYCLES / 2;

  // Register write hit: strobe qualified by one decoded offset
  function wr_hit;
    input        w;
    input [11:0] a;
    input [11:0] want;
    begin
      wr_hit = w & (a == want);
    end
  endfunction

  function [1:0] space_of;
    input [7:0] ctrl;
    begin
      if (ctrl[`NVAC_B_CONFIG_SPACE_SELECT])
        space_of = SP_CONFIG;
      else if (ctrl[`NVAC_B_SPACE])
        space_of = SP_FLASH;
      else
        space_of = SP_EEPROM;
    end
  endfunction

  reg [7:0]  ctrl_ff;
  reg [7:0]  eeprom_data_reg_ff;
  reg [7:0]  eeaddr_ff;
  reg [7:0]  tblu_ff;
  reg [7:0]  tblh_ff;
  reg [7:0]  tbll_ff;
  reg [7:0]  tblat_ff;
  reg [7:0]  flags2_ff;
  reg [7:0]  enables2_ff;
  reg [7:0]  prio2_ff;
  reg [1:0]  unlock_ff;
  reg [1:0]  state_ff;
  reg [31:0] timer_ff;
  reg [31:0] pwrt_ff;
  reg        rd_pend_ff;
  reg        erase_row_ff;
  reg        por_seen_ff;
  reg [1:0]  sel_keep_ff;

  wire acc     = psel & penable & clk_en;
  wire wr_acc  = acc & pwrite;
  wire rd_acc  = acc & ~pwrite;
  wire [7:0] wb = pwdata[7:0];
  wire busy    = (state_ff != ST_IDLE);
  wire pwrt_on = (pwrt_ff != 32'd0);
  wire wr_ctrl = wr_acc & (paddr == `NVAC_OFS_CTRL);
  wire wr_unl  = wr_acc & (paddr == `NVAC_OFS_UNLOCK);

  // Start needs enable already set, unlock done, idle and timer over
  wire start_ok = wr_ctrl & wb[`NVAC_B_WSTRT] & ~ctrl_ff[`NVAC_B_WSTRT]
                & ctrl_ff[`NVAC_B_WEN]
                & (unlock_ff == UL_K2)
                & ~busy & ~pwrt_on;
  wire bad_start = wr_ctrl & wb[`NVAC_B_WSTRT] & ~busy & ~start_ok;
  wire rd_ok = wr_ctrl & wb[`NVAC_B_RSTRT] & ~busy
             & ~wb[`NVAC_B_SPACE] & ~wb[`NVAC_B_CONFIG_SPACE_SELECT];
  wire timer_end = busy & (timer_ff == 32'd1);
  wire done_evt  = (state_ff == ST_PROG) & timer_end;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign write_done_flag = flags2_ff[`NVAC_B_DONE];
  // Core is held while flash or config is being written
  assign core_stall = busy & (mem_space != SP_EEPROM);

  // Read mux: unlock port, and bit 5 of CTRL, FLAGS2, ENABLES2 and PRIO2, read zero
  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `NVAC_OFS_CTRL:     prdata[7:0] = ctrl_ff & 8'hdf;
      `NVAC_OFS_UNLOCK:   prdata[7:0] = 8'h00;
      `NVAC_OFS_EEPROM_DATA_REG:   prdata[7:0] = eeprom_data_reg_ff;
      `NVAC_OFS_EEADDR:   prdata[7:0] = eeaddr_ff;
      `NVAC_OFS_TBLU:     prdata[7:0] = tblu_ff;
      `NVAC_OFS_TBLH:     prdata[7:0] = tblh_ff;
      `NVAC_OFS_TBLL:     prdata[7:0] = tbll_ff;
      `NVAC_OFS_TBLAT:    prdata[7:0] = tblat_ff;
      `NVAC_OFS_FLAGS2:   prdata[7:0] = flags2_ff & 8'hdf;
      `NVAC_OFS_ENABLES2: prdata[7:0] = enables2_ff & 8'hdf;
      `NVAC_OFS_PRIO2:    prdata[7:0] = prio2_ff & 8'hdf;
      `NVAC_OFS_STATUS:   prdata[3:0] = {pwrt_on, core_stall,
                                         rd_pend_ff, busy};
      default:            prdata = 32'h0000_0000;
    endcase
  end

  // Catch reset cause after release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_seen_ff <= 1'b0;
    end else if (!por_seen_ff) begin
      por_seen_ff <= 1'b1;
    end
  end

  // Copy of the space selection with no reset, so a warm reset
  // cannot lose which space the cut-short write was aimed at
  always @(posedge pclk) begin
    if (presetn && clk_en && por_seen_ff) begin
      sel_keep_ff <= {ctrl_ff[`NVAC_B_SPACE], ctrl_ff[`NVAC_B_CONFIG_SPACE_SELECT]};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Abort flag and space bits come back after a warm reset at the
      // first edge after release, if clk_en is high then; async reset loads constants only
      ctrl_ff      <= `NVAC_CTRL_RST;
      eeprom_data_reg_ff    <= 8'h00;
      eeaddr_ff    <= 8'h00;
      tblu_ff      <= 8'h00;
      tblh_ff      <= 8'h00;
      tbll_ff      <= 8'h00;
      tblat_ff     <= 8'h00;
      flags2_ff    <= 8'h00;
      enables2_ff  <= 8'h00;
      prio2_ff     <= 8'h00;
      unlock_ff    <= UL_NONE;
      state_ff     <= ST_IDLE;
      timer_ff     <= 32'd0;
      pwrt_ff      <= 32'd0;
      rd_pend_ff   <= 1'b0;
      erase_row_ff <= 1'b0;
      mem_space    <= SP_EEPROM;
      mem_addr     <= 8'h00;
      mem_tbl_addr <= 22'h000000;
      mem_wdata    <= 8'h00;
      mem_erase_pulse <= 1'b0;
      mem_wr_pulse <= 1'b0;
      mem_rd_pulse <= 1'b0;
    end else if (clk_en) begin
      mem_erase_pulse <= 1'b0;
      mem_wr_pulse    <= 1'b0;
      mem_rd_pulse    <= 1'b0;
      if (!por_seen_ff) begin
        // Power-up timer runs only after a power-on reset
        pwrt_ff <= por_flag ? PWRT_CYCLES[31:0] : 32'd0;
        // A warm reset mid-write leaves the abort flag high
        if (!por_flag) begin
          ctrl_ff[`NVAC_B_ABORT] <= 1'b1;
          ctrl_ff[`NVAC_B_SPACE] <= sel_keep_ff[1];
          ctrl_ff[`NVAC_B_CONFIG_SPACE_SELECT]  <= sel_keep_ff[0];
        end
      end else if (pwrt_on) begin
        pwrt_ff <= pwrt_ff - 32'd1;
      end

      // Unlock sequencer: any other write breaks the chain
      if (wr_unl) begin
        if (wb == `NVAC_KEY1)
          unlock_ff <= UL_K1;
        else if (wb == `NVAC_KEY2 && unlock_ff == UL_K1)
          unlock_ff <= UL_K2;
        else
          unlock_ff <= UL_NONE;
      end else if (wr_acc) begin
        unlock_ff <= UL_NONE;
      end

      if (wr_ctrl && !busy) begin
        ctrl_ff[`NVAC_B_SPACE] <= wb[`NVAC_B_SPACE];
        ctrl_ff[`NVAC_B_CONFIG_SPACE_SELECT]  <= wb[`NVAC_B_CONFIG_SPACE_SELECT];
        ctrl_ff[`NVAC_B_ERASE] <= wb[`NVAC_B_ERASE];
        ctrl_ff[`NVAC_B_WEN]   <= wb[`NVAC_B_WEN];
        // Abort flag rises when enable is set
        if (wb[`NVAC_B_WEN] && !ctrl_ff[`NVAC_B_WEN])
          ctrl_ff[`NVAC_B_ABORT] <= 1'b1;
        else if (bad_start)
          ctrl_ff[`NVAC_B_ABORT] <= 1'b1;
        else
          ctrl_ff[`NVAC_B_ABORT] <= wb[`NVAC_B_ABORT];
        if (rd_ok)
          ctrl_ff[`NVAC_B_RSTRT] <= 1'b1;
      end

      // Write start: set-only, chooses erase then program
      if (start_ok) begin
        ctrl_ff[`NVAC_B_WSTRT] <= 1'b1;
        unlock_ff    <= UL_NONE;
        mem_space    <= space_of(wb);
        mem_addr     <= eeaddr_ff;
        mem_tbl_addr <= {tblu_ff[5:0], tblh_ff, tbll_ff};
        mem_wdata    <= eeprom_data_reg_ff;
        erase_row_ff <= wb[`NVAC_B_ERASE] & space_of(wb) == SP_FLASH;
        state_ff     <= ST_ERASE;
        timer_ff     <= HALF_CYC;
        mem_erase_pulse <= 1'b1;
      end else if (timer_end && state_ff == ST_ERASE) begin
        if (erase_row_ff) begin
          // Row erase: no program pulse; one ST_PROG cycle, then done
          state_ff <= ST_PROG;
          timer_ff <= 32'd1;
        end else begin
          state_ff     <= ST_PROG;
          timer_ff     <= WRITE_CYCLES[31:0] - HALF_CYC;
          mem_wr_pulse <= 1'b1;
        end
      end else if (done_evt) begin
        state_ff <= ST_IDLE;
        timer_ff <= 32'd0;
        ctrl_ff[`NVAC_B_WSTRT] <= 1'b0;
        ctrl_ff[`NVAC_B_ABORT] <= 1'b0;
        if (erase_row_ff)
          ctrl_ff[`NVAC_B_ERASE] <= 1'b0;
      end else if (busy) begin
        timer_ff <= timer_ff - 32'd1;
      end

      // One-cycle read; data lands before the next access
      if (rd_ok) begin
        rd_pend_ff   <= 1'b1;
        mem_addr     <= eeaddr_ff;
        mem_space    <= SP_EEPROM;
        mem_rd_pulse <= 1'b1;
      end else if (rd_pend_ff) begin
        rd_pend_ff <= 1'b0;
        eeprom_data_reg_ff  <= mem_rdata;
        ctrl_ff[`NVAC_B_RSTRT] <= 1'b0;
      end else if (wr_acc && paddr == `NVAC_OFS_EEPROM_DATA_REG && !busy) begin
        eeprom_data_reg_ff <= wb;
      end

      if (wr_hit(wr_acc, paddr, `NVAC_OFS_EEADDR) && !busy)
        eeaddr_ff <= wb;
      if (wr_hit(wr_acc, paddr, `NVAC_OFS_TBLU))
        tblu_ff <= wb & `NVAC_TBLU_MASK;
      if (wr_hit(wr_acc, paddr, `NVAC_OFS_TBLH))
        tblh_ff <= wb;
      if (wr_hit(wr_acc, paddr, `NVAC_OFS_TBLL))
        tbll_ff <= wb;
      if (wr_hit(wr_acc, paddr, `NVAC_OFS_TBLAT))
        tblat_ff <= wb;
      if (wr_hit(wr_acc, paddr, `NVAC_OFS_ENABLES2))
        enables2_ff <= wb;
      if (wr_hit(wr_acc, paddr, `NVAC_OFS_PRIO2))
        prio2_ff <= wb;
      // Done flag: hardware set wins over a software clear
      if (wr_hit(wr_acc, paddr, `NVAC_OFS_FLAGS2))
        flags2_ff <= wb;
      if (done_evt)
        flags2_ff[`NVAC_B_DONE] <= 1'b1;
    end
  end

endmodule // nvac_ctrl

`default_nettype wire

/* File: verif/nvac_props.sv */
/* Assertions on the ports of nvac_ctrl.
   Assumes one pclk domain and the bind below. */
`default_nettype none
module nvac_props #(
  parameter int WRITE_CYCLES = 20,
  parameter int PWRT_CYCLES  = 40
) (
  // Clock, reset, cause
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        por_flag,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Memory side
  input wire logic [1:0]  mem_space,
  input wire logic        mem_erase_pulse,
  input wire logic        mem_wr_pulse,
  input wire logic        mem_rd_pulse,
  input wire logic        core_stall,
  input wire logic        write_done_flag
);
  localparam int BUSY = WRITE_CYCLES + 2;
  localparam int WMAX = WRITE_CYCLES + 4;
  logic        acc;
  logic [1:0]  key_ff;
  logic [15:0] since_ff;
  logic [15:0] cyc_ff;
  logic        por_ff;
  assign acc = psel && penable && clk_en;
  // Unlock progress, age of last start, age of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_ff   <= 2'h0;
      since_ff <= 16'hffff;
      cyc_ff   <= 16'h0000;
      por_ff   <= 1'b0;
    end else begin
      if (acc && pwrite)
        key_ff <= (paddr != 12'h004) ? 2'h0 :
                  (pwdata[7:0] == 8'h55) ? 2'h1 :
                  (pwdata[7:0] == 8'haa && key_ff == 2'h1) ? 2'h2 : 2'h0;
      if (mem_erase_pulse)
        since_ff <= 16'h0000;
      else if (since_ff != 16'hffff)
        since_ff <= since_ff + 16'h0001;
      if (cyc_ff != 16'hffff)
        cyc_ff <= cyc_ff + 16'h0001;
      if (cyc_ff == 16'h0000)
        por_ff <= por_flag;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence ctrl_wr;
    acc && pwrite && paddr == 12'h000;
  endsequence
  sequence rd_req;
    ctrl_wr ##0 pwdata[0];
  endsequence
  chk_rd_start: assert property (
    rd_req ##0 (pwdata[7:6] == 2'h0 && since_ff > BUSY) |=> mem_rd_pulse)
    else $error("read start gave no read pulse");
  chk_rd_refuse: assert property (
    rd_req ##0 pwdata[7:6] != 2'h0 |=> !mem_rd_pulse)
    else $error("read started outside eeprom space");
  chk_key_order: assert property (
    ctrl_wr ##0 (pwdata[1] && key_ff != 2'h2) |=> !mem_erase_pulse)
    else $error("write started without unlock keys");
  chk_unlock_zero: assert property (
    acc && !pwrite && paddr == 12'h004 |-> prdata == 32'h0)
    else $error("unlock port read not zero");
  chk_bit5_zero: assert property (
    acc && !pwrite && paddr == 12'h000 |-> !prdata[5])
    else $error("control bit 5 read one");
  chk_stall_space: assert property (
    core_stall |-> mem_space != 2'h0)
    else $error("core stalled for eeprom access");
  chk_done_bound: assert property (
    mem_erase_pulse && mem_space == 2'h0 |-> ##[1:WMAX] write_done_flag)
    else $error("done flag late after eeprom write");
  chk_erase_first: assert property (
    mem_wr_pulse && mem_space == 2'h0 |-> since_ff < WRITE_CYCLES)
    else $error("eeprom program without prior erase");
  chk_pwrt_block: assert property (
    por_ff && cyc_ff < PWRT_CYCLES |-> !mem_erase_pulse && !mem_wr_pulse)
    else $error("write during power-up timer");
endmodule // nvac_props
bind nvac_ctrl nvac_props #(
  .WRITE_CYCLES(WRITE_CYCLES), .PWRT_CYCLES(PWRT_CYCLES)) u_props (
  .pclk, .presetn, .clk_en, .por_flag, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .mem_space, .mem_erase_pulse, .mem_wr_pulse,
  .mem_rd_pulse, .core_stall, .write_done_flag);
`default_nettype wire

/* File: verif/test_eeprom_flash_access_control.sv */
/* Self-checking bench for nvac_ctrl over APB.
   Assumes the design and nvac_props are compiled first. */
`default_nettype none
module test_eeprom_flash_access_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WC = 20;
  localparam int PC = 40;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, por_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [7:0]  mem_rdata, rd;
  wire  [31:0] prdata;
  wire  [1:0]  mem_space;
  wire  [7:0]  mem_addr, mem_wdata;
  wire         pready, core_stall, write_done_flag, er_p, wr_p;
  int          errors = 0, checks_done = 0, er_n = 0, wr_n = 0, cyc = 0;
  nvac_ctrl #(.WRITE_CYCLES(WC), .PWRT_CYCLES(PC)) uut (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr(), .por_flag, .mem_space, .mem_addr,
    .mem_tbl_addr(), .mem_wdata, .mem_erase_pulse(er_p),
    .mem_wr_pulse(wr_p), .mem_rd_pulse(), .mem_rdata, .core_stall,
    .write_done_flag);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Pulse counters and hang guard
  always @(posedge pclk) begin
    cyc  <= cyc + 1;
    er_n <= er_n + int'(er_p);
    wr_n <= wr_n + int'(wr_p);
    if (cyc == 3000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata[7:0];
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmp(input string n, input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e,
                     input string n);
    apb(1'b0, a, 8'h00);
    cmp(n, e, rd);
  endtask
  task automatic go(input logic [7:0] c);
    apb(1'b1, 12'h004, 8'h55);
    apb(1'b1, 12'h004, 8'haa);
    apb(1'b1, 12'h000, c);
  endtask
  task automatic wait_idle;
    rd = 8'h02;
    while (rd[1]) apb(1'b0, 12'h000, 8'h00);
  endtask
  task automatic t_power_up;
    rdc(12'h000, 8'h00, "ctrl rst");
    rdc(12'h004, 8'h00, "unlock");
    apb(1'b1, 12'h000, 8'h04);
    go(8'h06);
    rdc(12'h000, 8'h0c, "pwrt");
    repeat (PC) @(posedge pclk);
  endtask
  task automatic t_read;
    mem_rdata <= 8'h3c;
    apb(1'b1, 12'h00c, 8'h5a);
    apb(1'b1, 12'h000, 8'h01);
    rdc(12'h008, 8'h3c, "rd data");
    rdc(12'h000, 8'h00, "rd clr");
    mem_rdata <= 8'h99;
    apb(1'b1, 12'h000, 8'h81);
    rdc(12'h000, 8'h80, "flash rd");
    apb(1'b1, 12'h000, 8'h41);
    rdc(12'h000, 8'h40, "cfg rd");
    rdc(12'h008, 8'h3c, "rd held");
  endtask
  task automatic t_order;
    apb(1'b1, 12'h000, 8'h00);
    go(8'h06);
    rdc(12'h000, 8'h0c, "same wr");
    apb(1'b1, 12'h004, 8'h55);
    apb(1'b1, 12'h008, 8'h77);
    apb(1'b1, 12'h004, 8'haa);
    apb(1'b1, 12'h000, 8'h06);
    rdc(12'h000, 8'h0c, "order");
  endtask
  task automatic t_write;
    int e0, w0;
    e0 = er_n;
    w0 = wr_n;
    apb(1'b1, 12'h00c, 8'h12);
    apb(1'b1, 12'h000, 8'h04);
    // Abort bit is software writable while idle: keep it set at start
    go(8'h0e);
    rdc(12'h000, 8'h0e, "busy");
    apb(1'b1, 12'h000, 8'h00);
    apb(1'b1, 12'h008, 8'h11);
    rdc(12'h000, 8'h0e, "locked");
    wait_idle();
    rdc(12'h000, 8'h04, "done");
    rdc(12'h008, 8'h77, "data");
    cmp("addr", 8'h12, mem_addr);
    cmp("wdata", 8'h77, mem_wdata);
    cmp("pulses", 8'h11, {4'(er_n - e0), 4'(wr_n - w0)});
    cmp("flag", 8'h01, {7'h0, write_done_flag});
    apb(1'b1, 12'h020, 8'h00);
    rdc(12'h020, 8'h00, "flag clr");
  endtask
  task automatic t_erase;
    int w0;
    w0 = wr_n;
    apb(1'b1, 12'h018, 8'h40);
    apb(1'b1, 12'h000, 8'h94);
    go(8'h96);
    repeat (2) @(negedge pclk);
    cmp("stall", 8'h01, {7'h0, core_stall});
    cmp("space", 8'h01, {6'h0, mem_space});
    wait_idle();
    rdc(12'h000, 8'h84, "erase end");
    cmp("no prog", 8'h00, 8'(wr_n - w0));
    apb(1'b1, 12'h000, 8'h44);
    go(8'h46);
    repeat (2) @(negedge pclk);
    cmp("cfg", 8'h02, {6'h0, mem_space});
    wait_idle();
  endtask
  task automatic t_warm;
    apb(1'b1, 12'h000, 8'h84);
    go(8'h86);
    por_flag <= 1'b0;
    presetn  <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdc(12'h000, 8'h88, "warm");
  endtask
  initial begin
    presetn   = 1'b0;
    clk_en    = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    por_flag  = 1'b1;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    mem_rdata = 8'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_power_up();
    t_read();
    t_order();
    t_write();
    t_erase();
    t_warm();
    end_sim();
  end
endmodule // test_eeprom_flash_access_control
`default_nettype wire
